//--- logic/ldm_pkg.sv
package ldm_pkg;
  localparam int CLK_NS = 8;
  localparam int DEB_NS = 200;
  localparam int DEB_CYC = (DEB_NS + CLK_NS - 1) / CLK_NS;
  localparam int TON_LSB_NS = 200;
  localparam int TON_CYC = TON_LSB_NS / CLK_NS;
  localparam int INIT_US = 150;
  localparam int INIT_CYC_DEF = INIT_US * 1000 / CLK_NS;
  localparam int OPEN_US = 50;
  localparam int OPEN_CYC_DEF = OPEN_US * 1000 / CLK_NS;
  localparam logic [6:0] ADDR_CTRL = 7'h10;
  localparam logic [6:0] ADDR_MEAS = 7'h11;
  localparam logic [6:0] ADDR_BUCK = 7'h12;
  localparam logic [6:0] ADDR_LED = 7'h13;
  localparam logic [6:0] ADDR_THERM = 7'h14;
  localparam logic [6:0] ADDR_BOOST = 7'h15;
  localparam logic [6:0] ADDR_TEMP = 7'h16;
  localparam logic [6:0] ADDR_STR = 7'h17;
  localparam logic [6:0] ADDR_STRON = 7'h18;
  localparam logic [1:0] CH_TEMP = 2'h1;
  localparam logic [4:0] BIT_HDR = 5'h08;
  localparam logic [4:0] BIT_LOAD = 5'h0c;
  localparam logic [4:0] BIT_LAST = 5'h1c;
  localparam logic [4:0] BIT_SAT = 5'h1f;
  localparam logic [7:0] THR_RST = 8'hb3;
  localparam logic [8:0] RES_RST = 9'h100;
  localparam int SY_DIM = 0;
  localparam int SY_RSTP = 1;
  localparam int SY_TSD = 2;
  localparam int SY_SHORT = 3;
  localparam int SY_OC = 4;
  localparam int SY_MINT = 5;
  localparam int SY_GATE = 6;
  localparam int SY_CS = 7;
  localparam int SY_OK = 8;
  localparam int SY_REQ = 9;
  localparam int SY_WR = 10;
  localparam logic [10:0] SY_RST = 11'h082;
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_NORMAL = 2'b01,
    ST_FSO = 2'b11
  } ldm_state_t;
  typedef struct packed {
    logic buck_en;
    logic auto_rcv;
    logic [1:0] rng;
    logic [7:0] thr;
  } ldm_ctrl_t;
  localparam ldm_ctrl_t CTRL_RST = '{1'b0, 1'b0, 2'h0, THR_RST};
  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [7:0] code;
  } ldm_adc_t;
  typedef struct packed {
    logic mode_prog;
    logic lock;
    logic [2:0] fs_mode;
  } ldm_otp_t;
endpackage

//--- logic/ldm_core.sv
// Notes on behaviour
// R1 - Boost voltage stored as 8-bit code
// R2 - Temperature stored as 8-bit code
// R3 - Range select sets string voltage scale
// R4 - Every result carries odd parity
// R5 - Constant dimming still forces string measurement
// R6 - Warning flag latches when temp reaches threshold
// R7 - Warning threshold resets to 179
// R8 - Shutdown stops buck until below warning
// R9 - Recovery automatic or on enable edge
// R10 - Serial error flag latches on bad frame
// R11 - Long on-time latches open flag, buck runs
// R12 - Short flag follows comparator, fixed off time
// R13 - Overcurrent latches flag, stops buck
// R14 - Buck status reads one while regulating
// R15 - Dimming level shown after 200 ns debounce
// R16 - Minimum on-time flag, cleared by read
// R17 - On-time kept in 200 ns steps
// R18 - Power-on flag set only by power-on reset
// R19 - Reset pin falling edge resets in some modes
// R20 - Init state lasts 150 us
// R21 - Fail-safe entry needs mode and lock bits
// R22 - Overcurrent hold released by reading flag
// R23 - Parity sits at bit 8
// R24 - Latched flags clear when their register read
`timescale 1ns/100ps
module ldm_core #(
  parameter int INIT_CYCLES = ldm_pkg::INIT_CYC_DEF,
  parameter int OPEN_CYCLES = ldm_pkg::OPEN_CYC_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  input wire ldm_pkg::ldm_adc_t adc_in,
  input wire logic adc_seq_done_in,
  input wire logic dim_control_input_in,
  input wire logic reset_pin_n_in,
  input wire logic tsd_trip_in,
  input wire logic short_cmp_in,
  input wire logic oc_limit_in,
  input wire logic min_on_time_in,
  input wire logic buck_gate_in,
  input wire ldm_pkg::ldm_otp_t otp_in,
  output logic buck_enable_out,
  output logic fixed_toff_out,
  output logic force_meas_out,
  output logic [1:0] string_volt_range_sel_out,
  output logic failsafe_standalone_mode_out
);
  import ldm_pkg::*;

  ldm_state_t state_q;
  logic [31:0] init_cnt_q;
  ldm_ctrl_t ctrl_q;
  logic [8:0] forced_meas_interval_q;
  logic [8:0] res_q [4];
  logic [10:0] sy1_q, sy2_q, sy3_q, sy_raw;
  logic [10:0] rise, fall, tog;
  logic [4:0] deb_cnt_q;
  logic dim_input_level_q, dim_prev_q;
  logic thermal_warn_flag_q, thermal_shutdown_flag_q;
  logic serial_error_flag_q, power_on_seen_flag_q;
  logic string_open_flag_q, string_short_flag_q, overcurrent_flag_q;
  logic min_on_time_flag_q, tsd_active_q, wait_en_q, oc_hold_q;
  logic buck_run_q, fixed_toff_q, force_q, en_prev_q;
  logic [4:0] pre_q;
  logic [7:0] units_q, on_time_duration_q;
  logic [31:0] open_cnt_q;
  logic [8:0] seq_cnt_q;
  logic [15:0] rdata_q;
  logic [7:0] temp;
  logic rd_ev, rd12, rd13, rd14, wr_ev, pin_rst, buck_run_d;
  // Link side
  logic armed_q, req_tog_q, wr_tog_q, ok_q;
  logic [4:0] cnt_q, lnk_n;
  logic [7:0] hdr_q;
  logic [15:0] sh_q;

  assign spi_miso_out = sh_q[15];
  assign buck_enable_out = buck_run_q;
  assign fixed_toff_out = fixed_toff_q;
  assign force_meas_out = force_q;
  assign string_volt_range_sel_out = ctrl_q.rng;
  assign failsafe_standalone_mode_out = state_q[1];

  assign sy_raw = {wr_tog_q, req_tog_q, ok_q, spi_cs_n_in, buck_gate_in,
    min_on_time_in, oc_limit_in, short_cmp_in, tsd_trip_in,
    reset_pin_n_in, dim_control_input_in};

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sy1_q <= SY_RST;
      sy2_q <= SY_RST;
      sy3_q <= SY_RST;
    end
    else
    begin
      sy1_q <= sy_raw;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  assign rise = sy2_q & ~sy3_q;
  assign fall = ~sy2_q & sy3_q;
  assign tog = sy2_q ^ sy3_q;
  // Header and shift word are stable once their toggle is seen here
  assign rd_ev = tog[SY_REQ] & ~hdr_q[7];
  assign rd12 = rd_ev && hdr_q[6:0] == ADDR_BUCK;
  assign rd13 = rd_ev && hdr_q[6:0] == ADDR_LED;
  assign rd14 = rd_ev && hdr_q[6:0] == ADDR_THERM;
  assign wr_ev = tog[SY_WR] & hdr_q[7];
  assign temp = res_q[CH_TEMP][7:0];
  // R19 - pin reset modes
  assign pin_rst = fall[SY_RSTP] && state_q != ST_INIT
    && otp_in.fs_mode[2] == otp_in.fs_mode[1];

  // R20 - init delay
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_INIT;
      init_cnt_q <= 32'h0;
    end
    else if (pin_rst)
    begin
      state_q <= ST_INIT;
      init_cnt_q <= 32'h0;
    end
    else if (state_q == ST_INIT)
    begin
      if (init_cnt_q == 32'(INIT_CYCLES - 1))
      begin
        // R21 - fail-safe entry gate
        if (otp_in.mode_prog && otp_in.lock)
          state_q <= ST_FSO;
        else
          state_q <= ST_NORMAL;
      end
      else
        init_cnt_q <= init_cnt_q + 32'h1;
    end
  end

  init_len_a: assert property (@(posedge clk_in) disable iff (rst_in) // R20
    state_q == ST_INIT && !pin_rst && init_cnt_q < 32'(INIT_CYCLES - 1)
    |=> state_q == ST_INIT)
    else $error("init left early");

  // R7 - threshold reset value
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_q <= CTRL_RST;
      forced_meas_interval_q <= 9'h0;
    end
    else if (pin_rst)
    begin
      ctrl_q <= CTRL_RST;
      forced_meas_interval_q <= 9'h0;
    end
    else if (wr_ev && hdr_q[6:0] == ADDR_CTRL)
      ctrl_q <= ldm_ctrl_t'(sh_q[11:0]);
    else if (wr_ev && hdr_q[6:0] == ADDR_MEAS)
      forced_meas_interval_q <= sh_q[8:0];
  end

  thr_reset_a: assert property (@(posedge clk_in) disable iff (rst_in) // R7
    $fell(rst_in) |-> ctrl_q.thr == THR_RST)
    else $error("threshold reset value wrong");

  // R1 R2 R3 R4 R23 - results with odd parity at bit 8
  for (genvar c = 0; c < 4; c++)
  begin : g_res
    always_ff @(posedge clk_in or posedge rst_in)
    begin
      if (rst_in)
        res_q[c] <= RES_RST;
      else if (adc_in.valid && adc_in.chan == 2'(c))
        res_q[c] <= {~^adc_in.code, adc_in.code};
    end
  end

  parity_a: assert property (@(posedge clk_in) disable iff (rst_in) // R4
    adc_in.valid |=> ^res_q[$past(adc_in.chan)])
    else $error("result parity not odd");

  // R15 - debounce filter
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      deb_cnt_q <= 5'h0;
      dim_input_level_q <= 1'b0;
    end
    else if (sy2_q[SY_DIM] == dim_input_level_q)
      deb_cnt_q <= 5'h0;
    else if (deb_cnt_q == 5'(DEB_CYC - 1))
    begin
      deb_cnt_q <= 5'h0;
      dim_input_level_q <= sy2_q[SY_DIM];
    end
    else
      deb_cnt_q <= deb_cnt_q + 5'h1;
  end

  // R24 - set wins over read clear in every flag below
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      thermal_warn_flag_q <= 1'b0;
      thermal_shutdown_flag_q <= 1'b0;
      serial_error_flag_q <= 1'b0;
      // R18 - power-on only
      power_on_seen_flag_q <= 1'b1;
    end
    else
    begin
      // R6 - warning compare
      if (temp >= ctrl_q.thr)
        thermal_warn_flag_q <= 1'b1;
      else if (rd14)
        thermal_warn_flag_q <= 1'b0;
      if (sy2_q[SY_TSD])
        thermal_shutdown_flag_q <= 1'b1;
      else if (rd14)
        thermal_shutdown_flag_q <= 1'b0;
      // R10 - frame length check
      if (rise[SY_CS] && !sy2_q[SY_OK])
        serial_error_flag_q <= 1'b1;
      else if (rd14)
        serial_error_flag_q <= 1'b0;
      if (rd14)
        power_on_seen_flag_q <= 1'b0;
    end
  end

  tw_set_a: assert property (@(posedge clk_in) disable iff (rst_in) // R6
    temp >= ctrl_q.thr |=> thermal_warn_flag_q)
    else $error("warning flag not set");
  ser_err_a: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    rise[SY_CS] && !sy2_q[SY_OK] |=> serial_error_flag_q)
    else $error("serial error not flagged");

  // R8 R9 - shutdown hold and recovery
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tsd_active_q <= 1'b0;
      wait_en_q <= 1'b0;
      en_prev_q <= 1'b0;
    end
    else
    begin
      en_prev_q <= ctrl_q.buck_en;
      if (sy2_q[SY_TSD])
        tsd_active_q <= 1'b1;
      else if (tsd_active_q && temp < ctrl_q.thr)
      begin
        tsd_active_q <= 1'b0;
        wait_en_q <= ~ctrl_q.auto_rcv;
      end
      else if (ctrl_q.buck_en && !en_prev_q)
        wait_en_q <= 1'b0;
    end
  end

  // R11 R12 R13 R16 R22 - LED faults
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      string_open_flag_q <= 1'b0;
      string_short_flag_q <= 1'b0;
      overcurrent_flag_q <= 1'b0;
      oc_hold_q <= 1'b0;
      min_on_time_flag_q <= 1'b0;
    end
    else
    begin
      if (sy2_q[SY_GATE] && open_cnt_q == 32'(OPEN_CYCLES - 1))
        string_open_flag_q <= 1'b1;
      else if (rd13)
        string_open_flag_q <= 1'b0;
      string_short_flag_q <= sy2_q[SY_SHORT];
      if (sy2_q[SY_OC])
      begin
        overcurrent_flag_q <= 1'b1;
        oc_hold_q <= 1'b1;
      end
      else if (rd13)
      begin
        overcurrent_flag_q <= 1'b0;
        oc_hold_q <= 1'b0;
      end
      if (sy2_q[SY_MINT])
        min_on_time_flag_q <= 1'b1;
      else if (rd12)
        min_on_time_flag_q <= 1'b0;
    end
  end

  // Pin dimming is ignored in fail-safe mode
  assign buck_run_d = state_q != ST_INIT && ctrl_q.buck_en
    && !tsd_active_q && !wait_en_q && !oc_hold_q
    && (state_q == ST_FSO || dim_input_level_q);

  // R14 - status from the run decision
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      buck_run_q <= 1'b0;
      fixed_toff_q <= 1'b0;
    end
    else
    begin
      buck_run_q <= buck_run_d;
      // R12 - fixed off time only while on
      fixed_toff_q <= string_short_flag_q && buck_run_q;
    end
  end

  tsd_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // R8
    tsd_active_q |=> !buck_run_q)
    else $error("buck runs in shutdown");
  // Hold is taken first, the run decision drops one cycle later
  sequence oc_stop_s;
    oc_hold_q ##1 !buck_run_q;
  endsequence

  oc_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    sy2_q[SY_OC] |=> oc_stop_s)
    else $error("buck runs after overcurrent");
  short_a: assert property (@(posedge clk_in) disable iff (rst_in) // R12
    string_short_flag_q && buck_run_q |=> fixed_toff_out)
    else $error("fixed off time missing");

  // R17 R11 - on-time in 200 ns units, open counter on one edge run
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pre_q <= 5'h0;
      units_q <= 8'h0;
      on_time_duration_q <= 8'h0;
      open_cnt_q <= 32'h0;
    end
    else if (sy2_q[SY_GATE])
    begin
      if (pre_q == 5'(TON_CYC - 1))
      begin
        pre_q <= 5'h0;
        if (units_q != 8'hff)
          units_q <= units_q + 8'h1;
      end
      else
        pre_q <= pre_q + 5'h1;
      if (open_cnt_q != 32'(OPEN_CYCLES - 1))
        open_cnt_q <= open_cnt_q + 32'h1;
    end
    else if (fall[SY_GATE])
    begin
      // Stopped buck never reaches here, so the last value stays
      on_time_duration_q <= units_q;
      pre_q <= 5'h0;
      units_q <= 8'h0;
      open_cnt_q <= 32'h0;
    end
  end

  // R5 - forced measurement when dimming stays constant
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      seq_cnt_q <= 9'h0;
      force_q <= 1'b0;
      dim_prev_q <= 1'b0;
    end
    else
    begin
      dim_prev_q <= dim_input_level_q;
      force_q <= 1'b0;
      if (dim_prev_q != dim_input_level_q)
        seq_cnt_q <= 9'h0;
      else if (adc_seq_done_in && forced_meas_interval_q != 9'h0)
      begin
        if (seq_cnt_q + 9'h1 == forced_meas_interval_q)
        begin
          seq_cnt_q <= 9'h0;
          force_q <= 1'b1;
        end
        else
          seq_cnt_q <= seq_cnt_q + 9'h1;
      end
    end
  end

  // Read answer; taken long before the link shifts it out
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_q <= 16'h0;
    else if (rd_ev)
    begin
      unique case (hdr_q[6:0])
        ADDR_CTRL: rdata_q <= {4'h0, ctrl_q};
        ADDR_MEAS: rdata_q <= {7'h0, forced_meas_interval_q};
        ADDR_BUCK: rdata_q <= {5'h0, dim_input_level_q, buck_run_q,
          min_on_time_flag_q, on_time_duration_q};
        ADDR_LED: rdata_q <= {13'h0, overcurrent_flag_q,
          string_short_flag_q, string_open_flag_q};
        ADDR_THERM: rdata_q <= {12'h0, power_on_seen_flag_q,
          serial_error_flag_q, thermal_shutdown_flag_q,
          thermal_warn_flag_q};
        ADDR_BOOST: rdata_q <= {7'h0, res_q[0]};
        ADDR_TEMP: rdata_q <= {7'h0, res_q[1]};
        ADDR_STR: rdata_q <= {7'h0, res_q[2]};
        ADDR_STRON: rdata_q <= {7'h0, res_q[3]};
        default: rdata_q <= 16'h0;
      endcase
    end
  end

  clr_read_a: assert property (@(posedge clk_in) disable iff (rst_in) // R24
    rd13 && !sy2_q[SY_OC] |=> !overcurrent_flag_q && !oc_hold_q)
    else $error("read did not clear");

  // Link clock only runs inside a frame; frame start is cleared by chip select
  always_ff @(posedge spi_clk_in or posedge rst_in or posedge spi_cs_n_in)
  begin
    if (rst_in || spi_cs_n_in)
      armed_q <= 1'b0;
    else
      armed_q <= 1'b1;
  end

  assign lnk_n = !armed_q ? 5'h01 :
    (cnt_q == BIT_SAT) ? cnt_q : cnt_q + 5'h1;

  always_ff @(posedge spi_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q <= 5'h0;
      hdr_q <= 8'h0;
      sh_q <= 16'h0;
      req_tog_q <= 1'b0;
      wr_tog_q <= 1'b0;
      ok_q <= 1'b0;
    end
    else
    begin
      cnt_q <= lnk_n;
      ok_q <= lnk_n == BIT_LAST;
      if (lnk_n <= BIT_HDR)
        hdr_q <= {hdr_q[6:0], spi_mosi_in};
      if (lnk_n == BIT_HDR)
        req_tog_q <= ~req_tog_q;
      if (lnk_n == BIT_LOAD)
        sh_q <= rdata_q;
      else if (lnk_n > BIT_LOAD && lnk_n <= BIT_LAST)
        sh_q <= {sh_q[14:0], spi_mosi_in};
      if (lnk_n == BIT_LAST && hdr_q[7])
        wr_tog_q <= ~wr_tog_q;
    end
  end

  lnk_req_a: assert property (@(posedge spi_clk_in) disable iff (rst_in)
    lnk_n == BIT_HDR |=> req_tog_q != $past(req_tog_q))
    else $error("header request not toggled");
endmodule

//--- testbench/ldm_mcu_model.sv
`timescale 1ns/100ps
module ldm_mcu_model (
  output logic spi_clk_out,
  output logic spi_cs_n_out,
  output logic spi_mosi_out,
  input wire logic spi_miso_in
);
  initial
  begin
    spi_clk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
  end

  // Link clock only toggles inside a frame; 48 ns period
  task automatic xfer(input logic wr, input logic [6:0] addr,
                      input logic [15:0] wdata, input int nbits,
                      output logic [15:0] rdata);
    logic [27:0] word;
    word = {wr, addr, 4'h0, wdata};
    rdata = 16'h0000;
    spi_cs_n_out = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      spi_mosi_out = word[27 - i];
      #24;
      if (i >= 12)
        rdata = {rdata[14:0], spi_miso_in};
      spi_clk_out = 1'b1;
      #24;
      spi_clk_out = 1'b0;
    end
    #24;
    spi_cs_n_out = 1'b1;
    // Released data line must not keep showing the last bit
    spi_mosi_out = ~spi_mosi_out;
    #48;
  endtask
endmodule

//--- testbench/ldm_core_tb.sv
`timescale 1ns/100ps
module ldm_core_tb;
  import ldm_pkg::*;
  logic clk_in, rst_in, spi_clk, spi_cs_n, spi_mosi, spi_miso;
  ldm_adc_t adc_in;
  ldm_otp_t otp_in;
  logic seq_done, dim, pin_n, thermal_shutdown_flag, shrt, oc, mint, gate;
  logic buck_en, toff, force_m, fso;
  logic [1:0] rng;
  int err_total, checks_done, fcnt;
  logic [6:0] ra [10];
  logic [15:0] rx [10];
  logic [15:0] d;

  ldm_core #(.INIT_CYCLES(20), .OPEN_CYCLES(50)) u_ldm_core (
    .clk_in(clk_in), .rst_in(rst_in), .spi_clk_in(spi_clk),
    .spi_cs_n_in(spi_cs_n), .spi_mosi_in(spi_mosi),
    .spi_miso_out(spi_miso), .adc_in(adc_in),
    .adc_seq_done_in(seq_done), .dim_control_input_in(dim),
    .reset_pin_n_in(pin_n), .tsd_trip_in(thermal_shutdown_flag), .short_cmp_in(shrt),
    .oc_limit_in(oc), .min_on_time_in(mint), .buck_gate_in(gate),
    .otp_in(otp_in), .buck_enable_out(buck_en),
    .fixed_toff_out(toff), .force_meas_out(force_m),
    .string_volt_range_sel_out(rng),
    .failsafe_standalone_mode_out(fso));

  ldm_mcu_model u_ldm_mcu_model (
    .spi_clk_out(spi_clk), .spi_cs_n_out(spi_cs_n),
    .spi_mosi_out(spi_mosi), .spi_miso_in(spi_miso));

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Sampled mid-cycle so the one-cycle pulse is seen exactly once
  always @(negedge clk_in)
    if (force_m === 1'b1)
      fcnt <= fcnt + 1;

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] r;
    u_ldm_mcu_model.xfer(1'b0, a, 16'h0000, 28, r);
    chk($sformatf("reg %h", a), r, exp);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    u_ldm_mcu_model.xfer(1'b1, a, v, 28, d);
    cyc(2);
  endtask

  task automatic adc(input logic [1:0] ch, input logic [7:0] code);
    cyc(1);
    adc_in = '{1'b1, ch, code};
    cyc(1);
    adc_in.valid = 1'b0;
    cyc(2);
  endtask

  task automatic do_reset();
    rst_in = 1'b1;
    cyc(10);
    rst_in = 1'b0;
  endtask

  task results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #500000;
    err_total++;
    results();
  end

  initial
  begin
    err_total = 0;
    checks_done = 0;
    fcnt = 0;
    adc_in = '0;
    otp_in = '0;
    {seq_done, dim, thermal_shutdown_flag, shrt, oc, mint, gate} = '0;
    pin_n = 1'b1;
    ra = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h14, 7'h15, 7'h16,
           7'h18, 7'h20};
    rx = '{16'h00b3, 16'h0000, 16'h0000, 16'h0000, 16'h0008, 16'h0000,
           16'h0100, 16'h0100, 16'h0100, 16'h0000};
    do_reset();
    cyc(30);
    // Reset values, power-on flag cleared by its read
    for (int i = 0; i < 10; i++)
      rd(ra[i], rx[i]);
    // Results with odd parity at bit 8
    adc(2'h0, 8'h5a);
    adc(2'h1, 8'hb3);
    adc(2'h2, 8'h00);
    adc(2'h3, 8'hff);
    rd(7'h15, 16'h015a);
    rd(7'h16, 16'h00b3);
    rd(7'h17, 16'h0100);
    rd(7'h18, 16'h01ff);
    rd(7'h14, 16'h0001);
    wr(7'h10, 16'h03b4);
    chk("range", {14'h0, rng}, 16'h0003);
    rd(7'h14, 16'h0001);
    rd(7'h14, 16'h0000);
    // Running buck: status and debounced dim level
    dim = 1'b1;
    wr(7'h10, 16'h0bb3);
    cyc(40);
    chk("buck on", {15'h0, buck_en}, 16'h0001);
    rd(7'h12, 16'h0600);
    gate = 1'b1;
    cyc(85);
    gate = 1'b0;
    cyc(5);
    chk("open keeps buck", {15'h0, buck_en}, 16'h0001);
    rd(7'h12, 16'h0603);
    rd(7'h13, 16'h0001);
    rd(7'h13, 16'h0000);
    gate = 1'b1;
    mint = 1'b1;
    cyc(10);
    {gate, mint} = 2'b00;
    cyc(5);
    rd(7'h12, 16'h0700);
    rd(7'h12, 16'h0600);
    // Dim glitch shorter than the debounce leaves the level alone
    dim = 1'b0;
    cyc(10);
    dim = 1'b1;
    cyc(30);
    rd(7'h12, 16'h0600);
    // Short string: fixed off time, buck keeps running
    shrt = 1'b1;
    cyc(6);
    chk("fixed toff", {15'h0, toff}, 16'h0001);
    chk("short buck", {15'h0, buck_en}, 16'h0001);
    rd(7'h13, 16'h0002);
    shrt = 1'b0;
    cyc(6);
    rd(7'h13, 16'h0000);
    // Overcurrent hold released only by reading the flag
    oc = 1'b1;
    cyc(6);
    chk("oc off", {15'h0, buck_en}, 16'h0000);
    oc = 1'b0;
    cyc(10);
    chk("oc hold", {15'h0, buck_en}, 16'h0000);
    rd(7'h13, 16'h0004);
    cyc(6);
    chk("oc release", {15'h0, buck_en}, 16'h0001);
    // Shutdown without auto recovery needs an enable edge
    adc(2'h1, 8'hc8);
    thermal_shutdown_flag = 1'b1;
    cyc(6);
    chk("tsd off", {15'h0, buck_en}, 16'h0000);
    thermal_shutdown_flag = 1'b0;
    cyc(10);
    chk("tsd hot", {15'h0, buck_en}, 16'h0000);
    adc(2'h1, 8'h10);
    cyc(10);
    chk("tsd no auto", {15'h0, buck_en}, 16'h0000);
    rd(7'h14, 16'h0003);
    wr(7'h10, 16'h03b3);
    wr(7'h10, 16'h0bb3);
    cyc(6);
    chk("tsd edge", {15'h0, buck_en}, 16'h0001);
    wr(7'h10, 16'h0fb3);
    thermal_shutdown_flag = 1'b1;
    cyc(10);
    thermal_shutdown_flag = 1'b0;
    cyc(10);
    chk("tsd auto", {15'h0, buck_en}, 16'h0001);
    rd(7'h14, 16'h0002);
    // Truncated frame raises the serial error flag
    u_ldm_mcu_model.xfer(1'b0, 7'h14, 16'h0000, 20, d);
    cyc(6);
    rd(7'h14, 16'h0004);
    // Forced measurement every second sequence with dim held
    wr(7'h11, 16'h0002);
    fcnt = 0;
    repeat (4)
    begin
      seq_done = 1'b1;
      cyc(1);
      seq_done = 1'b0;
      cyc(4);
    end
    chk("forced count", fcnt[15:0], 16'h0002);
    // Pin reset ignored in a fail-safe entry mode, taken in mode 000
    wr(7'h10, 16'h0ab3);
    otp_in = '{1'b0, 1'b0, 3'b010};
    pin_n = 1'b0;
    cyc(10);
    chk("pin 010", {14'h0, rng}, 16'h0002);
    pin_n = 1'b1;
    otp_in = '0;
    cyc(4);
    pin_n = 1'b0;
    cyc(10);
    chk("pin 000", {14'h0, rng}, 16'h0000);
    chk("pin buck", {15'h0, buck_en}, 16'h0000);
    pin_n = 1'b1;
    cyc(30);
    rd(7'h10, 16'h00b3);
    rd(7'h14, 16'h0000);
    // Init length and fail-safe entry gating
    otp_in = '{1'b1, 1'b1, 3'b110};
    do_reset();
    cyc(10);
    chk("init hold", {15'h0, fso}, 16'h0000);
    cyc(20);
    chk("fso entry", {15'h0, fso}, 16'h0001);
    // Stand-alone mode 110 keeps the pin reset working
    pin_n = 1'b0;
    cyc(10);
    chk("pin 110", {15'h0, fso}, 16'h0000);
    pin_n = 1'b1;
    otp_in = '{1'b1, 1'b0, 3'b110};
    do_reset();
    cyc(40);
    chk("no lock", {15'h0, fso}, 16'h0000);
    results();
  end
endmodule
